// ==== shared/fbt_pkg.sv ====
// Package of constants and types for the frame buffer timing generator
package fbt_pkg;
	// Parameter register indices (4-bit address, sixteen 8-bit registers)
	localparam logic [3:0] REG_START_OFFSET = 4'h0;
	localparam logic [3:0] REG_ROW_STRIDE = 4'h1;
	localparam logic [3:0] REG_REFRESH_ROWS = 4'h2;
	localparam logic [3:0] REG_ALT_FIELD = 4'h3;
	localparam logic [3:0] REG_EXT_SYNC = 4'h4;
	localparam logic [3:0] REG_SETUP = 4'h5;
	localparam logic [3:0] REG_ADDR_SENSE = 4'h6;
	localparam logic [3:0] REG_BPP = 4'h7;
	localparam logic [3:0] REG_RUN = 4'h8;
	localparam logic [3:0] REG_H_SYNC = 4'h9;
	localparam logic [3:0] REG_H_BP_A = 4'hA;
	localparam logic [3:0] REG_H_BP_B = 4'hB;
	localparam logic [3:0] REG_H_MID = 4'hC;
	localparam logic [3:0] REG_H_ACTIVE = 4'hD;
	localparam logic [3:0] REG_H_FRONT = 4'hE;
	localparam logic [3:0] REG_SERR = 4'hF;
	// Vertical lengths sit in a second bank reached with address bit 4
	localparam logic [4:0] REG_V_FRONT = 5'h10;
	localparam logic [4:0] REG_V_SYNC = 5'h11;
	localparam logic [4:0] REG_V_BACK = 5'h12;
	localparam logic [4:0] REG_V_ACTIVE = 5'h13;
	localparam logic [4:0] REG_STATUS = 5'h14;
	localparam logic [7:0] PARAM_RESET = 8'h00;
	// Fixed extra lengths of each region
	localparam logic [7:0] H_EXTRA = 8'h02;
	localparam logic [9:0] V_EXTRA_ONE = 10'h001;
	localparam logic [9:0] V_EXTRA_BACK = 10'h008;
	localparam logic [9:0] EQ_HALF_LINES = 10'h006; // three lines
	// Card clock: bus rate 10 MHz, card rate 20 MHz, system 250 MHz
	localparam int CLK_MHZ = 250;
	localparam int CARD_MHZ = 20;
	localparam int CARD_DIV = CLK_MHZ / CARD_MHZ; // rounds down
	localparam int DELAY_LINE_NS = 100;
	typedef enum logic [2:0] {HR_SYNC, HR_BPA, HR_BPB, HR_MID, HR_ACT, HR_FRONT} fbt_hreg_t;
	typedef enum logic [1:0] {VR_FRONT, VR_SYNC, VR_BACK, VR_ACT} fbt_vreg_t;
	typedef enum logic [1:0] {BS_IDLE, BS_SEL, BS_RAM, BS_ACK} fbt_bus_t;
endpackage : fbt_pkg

// ==== shared/fbt_tim_if.sv ====
// Interface carrying timing parameters and raster outputs
`timescale 1ns/1ps
interface fbt_tim_if;
	logic run;
	logic pix_en;
	logic [7:0] h_len [6];
	logic [7:0] serr;
	logic [7:0] v_len [4];
	logic interlace;
	logic hsync;
	logic vsync;
	logic csync;
	logic active;
	logic line_start;
	logic field;
	modport ctrl (output run, pix_en, h_len, serr, v_len, interlace, input hsync, vsync, csync, active,
		line_start, field);
	modport gen (input run, pix_en, h_len, serr, v_len, interlace, output hsync, vsync, csync, active,
		line_start, field);
endinterface : fbt_tim_if

// ==== rtl/fbt_raster.sv ====
// Horizontal and vertical raster generator with composite sync
`timescale 1ns/1ps
module fbt_raster
	import fbt_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	fbt_tim_if.gen t
);
	typedef struct packed {
		fbt_hreg_t hr;
		logic [7:0] hcnt;
		fbt_vreg_t vr;
		logic [9:0] vcnt;
		logic [7:0] scnt;
		logic field;
		logic hsync, vsync, csync, active, line_start;
	} fbt_rs_t;
	fbt_rs_t s_reg, s_next;
	logic [7:0] hlim;
	logic half_end;
	logic eq_zone;

	// Region length is parameter plus two scaled pixel clocks
	always_comb begin
		hlim = t.h_len[s_reg.hr] + H_EXTRA - 8'h01; // RULE15
		half_end = (s_reg.hcnt == hlim) && (s_reg.hr == HR_MID || s_reg.hr == HR_FRONT);
		eq_zone = (s_reg.vr == VR_FRONT && s_reg.vcnt + EQ_HALF_LINES > {2'b00, t.v_len[0]}) || // RULE21
			(s_reg.vr == VR_BACK && s_reg.vcnt < EQ_HALF_LINES); // RULE21
	end

	always_comb begin
		s_next = s_reg;
		s_next.line_start = 1'b0;
		if (!t.run) begin
			s_next = '0; // RULE26
		end else if (t.pix_en) begin
			if (s_reg.hcnt == hlim) begin
				s_next.hcnt = '0;
				if (s_reg.hr == HR_FRONT) begin
					s_next.hr = HR_SYNC; // RULE25
					s_next.line_start = 1'b1;
				end else begin
					s_next.hr = fbt_hreg_t'(s_reg.hr + 3'd1); // RULE25
				end
			end else begin
				s_next.hcnt = s_reg.hcnt + 8'h01;
			end
			// Vertical counter steps in half-line periods
			if (half_end) begin
				if (s_reg.vcnt == {2'b00, t.v_len[s_reg.vr]} + ((s_reg.vr == VR_BACK) ? V_EXTRA_BACK : V_EXTRA_ONE)
					- 10'h001) begin // RULE20 RULE22 RULE23 RULE24
					s_next.vcnt = '0;
					s_next.vr = fbt_vreg_t'(s_reg.vr + 2'd1);
					if (s_reg.vr == VR_ACT && t.interlace) begin
						s_next.field = ~s_reg.field; // RULE10
					end
				end else begin
					s_next.vcnt = s_reg.vcnt + 10'h001;
				end
			end
			// Serration spacing counter, independent of line length
			s_next.scnt = (s_reg.scnt == t.serr) ? 8'h00 : s_reg.scnt + 8'h01; // RULE19
			s_next.hsync = (s_next.hr == HR_SYNC);
			s_next.vsync = (s_next.vr == VR_SYNC);
			s_next.active = (s_next.hr == HR_ACT) && (s_next.vr == VR_ACT); // RULE18
			// Composite sync: serrations in sync, equalization near it, else plain hsync
			if (s_next.vr == VR_SYNC) begin
				s_next.csync = !((s_next.hr == HR_SYNC || s_next.hr == HR_ACT) && s_reg.scnt < t.serr); // RULE22
			end else if (eq_zone) begin
				s_next.csync = (s_next.hr == HR_SYNC || s_next.hr == HR_ACT) &&
					(s_next.hcnt < (t.h_len[0] >> 1)); // RULE16 RULE18
			end else begin
				s_next.csync = s_next.hsync;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign t.hsync = s_reg.hsync;
	assign t.vsync = s_reg.vsync;
	assign t.csync = s_reg.csync;
	assign t.active = s_reg.active;
	assign t.line_start = s_reg.line_start;
	assign t.field = s_reg.field;
endmodule : fbt_raster

// ==== rtl/fbt_top.sv ====
// Frame buffer timing generator top: bus strobes, parameter registers, card clock
//
// What this block does
// RULE1: Latch bus address on falling address strobe; no RAM cycle while strobe inactive.
// RULE2: Keep address strobe asserted until acknowledge goes back to bus master.
// RULE3: Bank select asserted means RAM cycle starts on next bus clock.
// RULE4: Start RAM cycle when bank select and strobe active and no refresh.
// RULE5: Card clock at twice bus clock, derived from bus clock timing; the code divides the system clock by 12, not locked to the bus clock.
// RULE6: Sixteen 8-bit parameter registers in control space, loaded at initialisation.
// RULE7: Start offset gives RAM offset of upper-left displayed pixel.
// RULE8: Row stride is byte distance between scanned lines over four.
// RULE9: Refresh the programmed number of RAM rows per scan line.
// RULE10: Alternate field scan value one means interlaced, else non-interlaced.
// RULE11: External sync select one takes sync from outside; zero internal.
// RULE12: Address sense forced zero in reset; software writes one afterwards.
// RULE13: Bits per pixel prescales pixel clock; written before run is set.
// RULE14: Run one means normal operation; zero holds controller in reset.
// RULE15: Each horizontal region lasts its parameter plus two scaled pixel clocks.
// RULE16: Equalization pulse width is horizontal sync length halved.
// RULE17: Software sizes back porch B for worst bus cycle plus three clocks.
// RULE18: Active video runs from line midpoint to front porch start.
// RULE19: Serration spacing sets serration interval, not line length.
// RULE20: Vertical front porch lasts its parameter plus one half-lines.
// RULE21: Equalization pulses in last three front porch, first three back porch lines.
// RULE22: Vertical sync lasts its parameter plus one half-lines, serrated each half-line.
// RULE23: Vertical back porch lasts its parameter plus eight half-lines.
// RULE24: Vertical active lasts its parameter plus one half-lines.
// RULE25: Horizontal regions step zero to five and wrap to zero.
// RULE26: With run at zero counters hold at start and video stays off.
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module fbt_top
	import fbt_pkg::*;
#(
	parameter int ADDR_W = 22
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Register port
	input wire logic [4:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// Slot bus side
	input wire logic BUS_START,
	input wire logic BUS_SLOT_HIT,
	input wire logic BUS_RAM_SPACE,
	input wire logic BUS_CLK_EN,
	input wire logic [ADDR_W-1:0] BUS_ADDR,
	output logic BUS_ACK,
	// Frame buffer controller side
	input wire logic REFRESH_BUSY,
	input wire logic RAM_DONE,
	output logic ADDRESS_STROBE_N,
	output logic BANK_SELECT_N,
	output logic RAM_CYCLE_START,
	output logic [ADDR_W-1:0] LATCHED_ADDR,
	output logic CARD_CLOCK_2X,
	output logic CARD_CLOCK_EN,
	output logic PIXEL_CLOCK_EN,
	// Video timing and parameters out
	input wire logic EXT_HSYNC,
	input wire logic EXT_VSYNC,
	output logic HSYNC,
	output logic VSYNC,
	output logic CSYNC,
	output logic VIDEO_ACTIVE,
	output logic FIELD_ODD,
	output logic [7:0] DISPLAY_START_OFFSET,
	output logic [7:0] ROW_STRIDE_WORDS,
	output logic REFRESH_REQ,
	output logic CTRL_RUN
);
	typedef struct packed {
		logic [15:0][7:0] prm;
		logic [3:0][7:0] vprm;
		fbt_bus_t bs;
		logic as_n;
		logic bsel_n;
		logic ram_go;
		logic ack;
		logic [ADDR_W-1:0] addr;
		logic [7:0] rdata;
		logic [7:0] cdiv;
		logic card_clk;
		logic [7:0] pdiv;
		logic [7:0] rfcnt;
		logic rfreq;
	} fbt_st_t;
	fbt_st_t s_reg, s_next;
	fbt_tim_if tim ();
	logic run;
	logic [7:0] pdiv_lim;

	assign run = s_reg.prm[REG_RUN][0];

	// Parameters shared with the raster generator
	always_comb begin
		tim.run = run; // RULE14
		tim.interlace = (s_reg.prm[REG_ALT_FIELD] == 8'h01); // RULE10
		tim.serr = s_reg.prm[REG_SERR];
		tim.h_len[0] = s_reg.prm[REG_H_SYNC];
		tim.h_len[1] = s_reg.prm[REG_H_BP_A];
		tim.h_len[2] = s_reg.prm[REG_H_BP_B];
		tim.h_len[3] = s_reg.prm[REG_H_MID];
		tim.h_len[4] = s_reg.prm[REG_H_ACTIVE];
		tim.h_len[5] = s_reg.prm[REG_H_FRONT];
		for (int i = 0; i < 4; i++) begin
			tim.v_len[i] = s_reg.vprm[i];
		end
		// Depth prescales the pixel clock: one card clock per pixel at depth 1, one more per step
		pdiv_lim = (s_reg.prm[REG_BPP] == 8'h00) ? 8'h00 : s_reg.prm[REG_BPP] - 8'h01; // RULE13
		tim.pix_en = s_reg.card_clk && s_reg.cdiv == 8'h00 && s_reg.pdiv == pdiv_lim;
	end

	fbt_raster u_raster (
		.clk(CLK),
		.reset(RESET),
		.t(tim.gen)
	);

	// Next state: registers, bus handshake, clock dividers
	always_comb begin
		s_next = s_reg;
		s_next.ram_go = 1'b0;
		s_next.rdata = 8'h00;
		// Register writes; control space is separate from frame buffer space
		if (REG_WR) begin
			if (REG_ADDR[4]) begin
				if (REG_ADDR[3:2] == 2'b00) begin
					s_next.vprm[REG_ADDR[1:0]] = REG_WDATA;
				end
			end else begin
				s_next.prm[REG_ADDR[3:0]] = REG_WDATA; // RULE6
			end
		end
		// Reads return one cycle later; unmapped addresses read zero
		if (REG_RD) begin
			if (!REG_ADDR[4]) begin
				s_next.rdata = s_reg.prm[REG_ADDR[3:0]];
			end else if (REG_ADDR[3:2] == 2'b00) begin
				s_next.rdata = s_reg.vprm[REG_ADDR[1:0]];
			end else if (REG_ADDR == REG_STATUS) begin
				s_next.rdata = {2'b00, tim.field, tim.active, tim.vsync, tim.hsync, s_reg.as_n, s_reg.bsel_n};
			end
		end
		// Card clock: half-period toggles from the system clock
		if (s_reg.cdiv == 8'(CARD_DIV / 2 - 1)) begin
			s_next.cdiv = 8'h00;
			s_next.card_clk = ~s_reg.card_clk; // RULE5
			if (s_reg.card_clk) begin
				s_next.pdiv = (s_reg.pdiv == pdiv_lim) ? 8'h00 : s_reg.pdiv + 8'h01;
			end
		end else begin
			s_next.cdiv = s_reg.cdiv + 8'h01;
		end
		// Refresh request: programmed row count issued at each line start
		s_next.rfreq = 1'b0;
		if (tim.line_start) begin
			s_next.rfcnt = s_reg.prm[REG_REFRESH_ROWS]; // RULE9
		end else if (s_reg.rfcnt != 8'h00 && !REFRESH_BUSY) begin
			s_next.rfcnt = s_reg.rfcnt - 8'h01;
			s_next.rfreq = 1'b1; // RULE9
		end
		// Bus transaction sequence
		unique case (s_reg.bs)
			BS_IDLE: begin
				if (BUS_START && BUS_SLOT_HIT && run) begin
					s_next.as_n = 1'b0; // RULE1
					s_next.addr = s_reg.prm[REG_ADDR_SENSE][0] ? ~BUS_ADDR : BUS_ADDR; // RULE1 RULE12
					s_next.bs = BUS_RAM_SPACE ? BS_SEL : BS_ACK;
				end
			end
			BS_SEL: begin
				s_next.bsel_n = 1'b0; // RULE3
				s_next.bs = BS_RAM;
			end
			BS_RAM: begin
				// Wait for next bus clock and a free refresh slot
				if (BUS_CLK_EN && !s_reg.as_n && !s_reg.bsel_n && !REFRESH_BUSY) begin
					s_next.ram_go = 1'b1; // RULE3 RULE4
				end
				if (RAM_DONE) begin
					s_next.bs = BS_ACK;
				end
			end
			BS_ACK: begin
				s_next.ack = 1'b1;
				if (s_reg.ack) begin
					s_next.ack = 1'b0;
					s_next.as_n = 1'b1; // RULE2
					s_next.bsel_n = 1'b1;
					s_next.bs = BS_IDLE;
				end
			end
		endcase
		// Run at zero holds bus sequence, strobes, ack and refresh count in reset; clock dividers keep running
		if (!run) begin
			s_next.bs = BS_IDLE; // RULE14
			s_next.as_n = 1'b1;
			s_next.bsel_n = 1'b1;
			s_next.ack = 1'b0;
			s_next.rfcnt = 8'h00;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			s_reg <= '0; // RULE12
			s_reg.as_n <= 1'b1;
			s_reg.bsel_n <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs
	assign REG_RDATA = s_reg.rdata;
	assign BUS_ACK = s_reg.ack;
	assign ADDRESS_STROBE_N = s_reg.as_n;
	assign BANK_SELECT_N = s_reg.bsel_n;
	assign RAM_CYCLE_START = s_reg.ram_go;
	assign LATCHED_ADDR = s_reg.addr;
	assign CARD_CLOCK_2X = s_reg.card_clk;
	assign CARD_CLOCK_EN = s_reg.card_clk && s_reg.cdiv == 8'h00;
	assign PIXEL_CLOCK_EN = tim.pix_en;
	assign REFRESH_REQ = s_reg.rfreq;
	assign CTRL_RUN = run;
	assign DISPLAY_START_OFFSET = s_reg.prm[REG_START_OFFSET]; // RULE7
	assign ROW_STRIDE_WORDS = s_reg.prm[REG_ROW_STRIDE]; // RULE8
	// External mode takes hsync and vsync straight from the outside source; composite sync is their XOR
	assign HSYNC = s_reg.prm[REG_EXT_SYNC] == 8'h01 ? EXT_HSYNC : tim.hsync; // RULE11
	assign VSYNC = s_reg.prm[REG_EXT_SYNC] == 8'h01 ? EXT_VSYNC : tim.vsync; // RULE11
	assign CSYNC = s_reg.prm[REG_EXT_SYNC] == 8'h01 ? (EXT_HSYNC ^ EXT_VSYNC) : tim.csync;
	assign VIDEO_ACTIVE = tim.active;
	assign FIELD_ODD = tim.field;
endmodule : fbt_top

// ==== sim/fbt_top_checker.sv ====
// Port-level assertions for the frame buffer timing generator top
`timescale 1ns/1ps
module fbt_top_checker
	import fbt_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Register port
	input wire logic [4:0] REG_ADDR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	// Bus and controller side
	input wire logic BUS_START,
	input wire logic BUS_SLOT_HIT,
	input wire logic BUS_RAM_SPACE,
	input wire logic BUS_CLK_EN,
	input wire logic BUS_ACK,
	input wire logic REFRESH_BUSY,
	input wire logic ADDRESS_STROBE_N,
	input wire logic BANK_SELECT_N,
	input wire logic RAM_CYCLE_START,
	// Video side
	input wire logic VIDEO_ACTIVE,
	input wire logic CTRL_RUN
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	// Transfer handshake
	property p_take;
		BUS_START && BUS_SLOT_HIT && CTRL_RUN && ADDRESS_STROBE_N && !BUS_ACK |=> !ADDRESS_STROBE_N;
	endproperty
	a_take: assert property (p_take) else $error("strobe not opened");
	property p_ram_strobe;
		RAM_CYCLE_START |-> !ADDRESS_STROBE_N;
	endproperty
	a_ram_strobe: assert property (p_ram_strobe) else $error("RAM cycle without strobe");
	property p_ram_bank;
		RAM_CYCLE_START |-> !BANK_SELECT_N;
	endproperty
	a_ram_bank: assert property (p_ram_bank) else $error("RAM cycle without bank");
	// Strobe may only close once the acknowledge has gone out
	property p_release;
		$rose(ADDRESS_STROBE_N) |-> $past(BUS_ACK);
	endproperty
	a_release: assert property (p_release) else $error("strobe closed early");
	property p_ctrl_ack;
		$fell(ADDRESS_STROBE_N) && BANK_SELECT_N && !$past(BUS_RAM_SPACE) |-> ##[1:2] BUS_ACK;
	endproperty
	a_ctrl_ack: assert property (p_ctrl_ack) else $error("control access not acknowledged");
	property p_refresh;
		RAM_CYCLE_START |-> $past(BUS_CLK_EN && !REFRESH_BUSY);
	endproperty
	a_refresh: assert property (p_refresh) else $error("RAM cycle during refresh");
	property p_refused;
		BUS_START && BUS_SLOT_HIT && !CTRL_RUN && ADDRESS_STROBE_N |=> ADDRESS_STROBE_N;
	endproperty
	a_refused: assert property (p_refused) else $error("bus taken while stopped");
	property p_rd_run;
		REG_RD && REG_ADDR == 5'(REG_RUN) |=> REG_RDATA[0] == CTRL_RUN;
	endproperty
	a_rd_run: assert property (p_rd_run) else $error("run read back wrong");
	// Two quiet cycles allow the registered video flag to drain
	property p_video_off;
		!CTRL_RUN && $past(!CTRL_RUN) && $past(!CTRL_RUN, 2) |-> !VIDEO_ACTIVE;
	endproperty
	a_video_off: assert property (p_video_off) else $error("video while stopped");
	c_ram: cover property (RAM_CYCLE_START);
	c_ack: cover property ($rose(BUS_ACK));
	c_video: cover property ($rose(VIDEO_ACTIVE));
endmodule : fbt_top_checker
bind fbt_top fbt_top_checker u_chk (.CLK, .RESET, .REG_ADDR, .REG_RD, .REG_RDATA, .BUS_START, .BUS_SLOT_HIT,
	.BUS_RAM_SPACE, .BUS_CLK_EN, .BUS_ACK, .REFRESH_BUSY, .ADDRESS_STROBE_N, .BANK_SELECT_N, .RAM_CYCLE_START,
	.VIDEO_ACTIVE, .CTRL_RUN);

// ==== sim/fbt_bus_model.sv ====
// Slot bus master model: bus clock enable and single transactions
`timescale 1ns/1ps
module fbt_bus_model #(
	parameter int AW = 22
) (
	// Clock and answer
	input wire logic clk,
	input wire logic ack,
	// Request
	output logic start,
	output logic slot_hit,
	output logic ram_space,
	output logic clk_en,
	output logic [AW-1:0] addr
);
	int div = 0;
	initial begin
		start = 1'b0;
		slot_hit = 1'b0;
		ram_space = 1'b0;
		clk_en = 1'b0;
		addr = '0;
	end
	// One pulse in 25 system clocks gives the 10 MHz bus clock
	always @(posedge clk) begin
		div <= (div == 24) ? 0 : div + 1;
		clk_en <= (div == 24);
	end
	// Request is held until acknowledge or 400 clocks; released address shows its inverse, not a stale copy
	task automatic xfer(input logic ram, input logic [AW-1:0] a, input int lag, output int n);
		n = 0;
		repeat (lag + 1) @(posedge clk);
		start <= 1'b1;
		slot_hit <= 1'b1;
		ram_space <= ram;
		addr <= a;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 400);
		start <= 1'b0;
		slot_hit <= 1'b0;
		addr <= ~a;
	endtask : xfer
endmodule : fbt_bus_model

// ==== sim/test_frame_buffer_timing_gen.sv ====
// Self-checking bench for the frame buffer timing generator
`timescale 1ns/1ps
module test_frame_buffer_timing_gen
	import fbt_pkg::*;
;
	logic CLK, RESET, REG_WR, REG_RD, BUS_START, BUS_SLOT_HIT, BUS_RAM_SPACE, BUS_CLK_EN, BUS_ACK;
	logic REFRESH_BUSY, RAM_DONE, ADDRESS_STROBE_N, BANK_SELECT_N, RAM_CYCLE_START, CARD_CLOCK_2X;
	logic CARD_CLOCK_EN, PIXEL_CLOCK_EN, EXT_HSYNC, EXT_VSYNC, HSYNC, VSYNC, CSYNC, VIDEO_ACTIVE;
	logic FIELD_ODD, REFRESH_REQ, CTRL_RUN;
	logic [4:0] REG_ADDR;
	logic [7:0] REG_WDATA, REG_RDATA, DISPLAY_START_OFFSET, ROW_STRIDE_WORDS;
	logic [21:0] BUS_ADDR, LATCHED_ADDR;
	int miscompares = 0;
	int tests_run = 0;
	int cyc = 0;
	fbt_top dut (.CLK, .RESET, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .BUS_START, .BUS_SLOT_HIT,
		.BUS_RAM_SPACE, .BUS_CLK_EN, .BUS_ADDR, .BUS_ACK, .REFRESH_BUSY, .RAM_DONE, .ADDRESS_STROBE_N,
		.BANK_SELECT_N, .RAM_CYCLE_START, .LATCHED_ADDR, .CARD_CLOCK_2X, .CARD_CLOCK_EN, .PIXEL_CLOCK_EN,
		.EXT_HSYNC, .EXT_VSYNC, .HSYNC, .VSYNC, .CSYNC, .VIDEO_ACTIVE, .FIELD_ODD, .DISPLAY_START_OFFSET,
		.ROW_STRIDE_WORDS, .REFRESH_REQ, .CTRL_RUN);
	fbt_bus_model #(.AW(22)) bm (.clk(CLK), .ack(BUS_ACK), .start(BUS_START), .slot_hit(BUS_SLOT_HIT),
		.ram_space(BUS_RAM_SPACE), .clk_en(BUS_CLK_EN), .addr(BUS_ADDR));
	// 250 MHz clock
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	// Hang guard, well above the few frames the run needs
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares++;
			conclude();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLK);
		REG_WR <= 1'b0;
	endtask : wr
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLK);
		REG_RD <= 1'b0;
		@(posedge CLK);
		chk(REG_RDATA, e);
	endtask : rd
	// Rise to rise of one raster output: pixel steps, steps high, lines begun, refreshes, composite sync steps
	task automatic span(input int sel, output int per, output int hi, output int ln, output int rf,
		output int cs, output logic f);
		logic s, ps, ph;
		int k;
		k = 0;
		{per, hi, ln, rf, cs} = '0;
		ps = 1'b1;
		ph = 1'b1;
		f = FIELD_ODD;
		while (k < 2) begin
			@(posedge CLK);
			s = (sel == 2) ? VIDEO_ACTIVE : (sel == 1) ? VSYNC : HSYNC;
			if (s && !ps) begin
				k++;
				if (k == 1) f = FIELD_ODD;
			end
			if (k == 1) begin
				per += int'(PIXEL_CLOCK_EN);
				hi += int'(s & PIXEL_CLOCK_EN);
				ln += int'(HSYNC & !ph);
				rf += int'(REFRESH_REQ);
				cs += int'(CSYNC & PIXEL_CLOCK_EN);
			end
			ps = s;
			ph = HSYNC;
		end
	endtask : span
	task automatic t_reset();
		int n;
		for (int i = 0; i < 20; i++) rd(5'(i), 8'h00);
		rd(5'(REG_ADDR_SENSE), 8'h00);
		bm.xfer(1'b0, 22'h0000F0, 0, n);
		chk(n, 400);
		chk(ADDRESS_STROBE_N, 1'b1);
	endtask : t_reset
	// Line of 22 pixels, frame of 18 half-lines; run is written last
	task automatic t_init();
		logic [7:0] hv [6] = '{8'h01, 8'h01, 8'h02, 8'h01, 8'h04, 8'h01};
		logic [7:0] vv [4] = '{8'h01, 8'h01, 8'h01, 8'h04};
		wr(5'(REG_ADDR_SENSE), 8'h01);
		wr(5'(REG_BPP), 8'h01);
		wr(5'(REG_START_OFFSET), 8'h3C);
		wr(5'(REG_ROW_STRIDE), 8'hA0);
		wr(5'(REG_REFRESH_ROWS), 8'h02);
		for (int i = 0; i < 6; i++) wr(5'(REG_H_SYNC) + 5'(i), hv[i]);
		for (int i = 0; i < 4; i++) wr(REG_V_FRONT + 5'(i), vv[i]);
		// Status is read-only and the rest of the upper bank is unmapped
		wr(5'h14, 8'h5A);
		wr(5'h15, 8'hA5);
		rd(5'h14, 8'h03);
		rd(5'h15, 8'h00);
		rd(5'(REG_H_BP_B), 8'h02);
		wr(5'(REG_RUN), 8'h01);
		rd(5'(REG_RUN), 8'h01);
		chk(DISPLAY_START_OFFSET, 8'h3C);
		chk(ROW_STRIDE_WORDS, 8'hA0);
	endtask : t_init
	task automatic t_ctrl();
		int n;
		bm.xfer(1'b0, 22'h2A5F0C, 2, n);
		chk(n < 6, 1'b1);
		repeat (2) @(posedge CLK);
		chk(LATCHED_ADDR, 22'h15A0F3);
	endtask : t_ctrl
	// RAM access with refresh held for hold cycles first, none when hold is zero
	task automatic t_ram(input int hold);
		int n, m, seen;
		seen = 0;
		@(posedge CLK);
		REFRESH_BUSY <= (hold > 0);
		fork
			bm.xfer(1'b1, 22'h01F0A4, 0, n);
			begin
				repeat (hold) begin
					@(posedge CLK);
					seen += int'(RAM_CYCLE_START);
				end
				// With no hold the busy line was already lowered at the start
				if (hold > 0) begin
					REFRESH_BUSY <= 1'b0;
				end
				chk(seen, 0);
				m = 0;
				do begin
					@(posedge CLK);
					m++;
				end while (RAM_CYCLE_START !== 1'b1 && m < 100);
				chk(m < 100, 1'b1);
				chk(BANK_SELECT_N, 1'b0);
				RAM_DONE <= 1'b1;
				@(posedge CLK);
				RAM_DONE <= 1'b0;
			end
		join
		chk(n < 400, 1'b1);
	endtask : t_ram
	task automatic t_raster();
		int p, h, l, r, c, s;
		logic f;
		c = 0;
		span(0, p, h, l, r, s, f);
		chk(p, 22);
		chk(h, 3);
		chk(r, 2);
		span(1, p, h, l, r, s, f);
		chk(l, 9);
		chk(h, 22);
		chk(FIELD_ODD, f);
		// A line inside vertical active carries no equalization: composite sync is the line sync
		span(2, p, h, l, r, s, f);
		chk(p, 22);
		chk(h, 6);
		chk(s, 3);
		wr(5'(REG_ALT_FIELD), 8'h01);
		span(1, p, h, l, r, s, f);
		chk(FIELD_ODD, !f);
		repeat (240) begin
			@(posedge CLK);
			c += int'(CARD_CLOCK_EN);
		end
		chk(c, 240 / CARD_DIV);
	endtask : t_raster
	task automatic t_stop_ext();
		int c;
		c = 0;
		wr(5'(REG_RUN), 8'h00);
		// The registered video flag needs two cycles to drain
		repeat (2) @(posedge CLK);
		repeat (300) begin
			@(posedge CLK);
			c += int'(VIDEO_ACTIVE);
		end
		chk(c, 0);
		// Depth changes only while stopped: two card clocks per pixel
		wr(5'(REG_BPP), 8'h02);
		c = 0;
		repeat (240) begin
			@(posedge CLK);
			c += int'(PIXEL_CLOCK_EN);
		end
		chk(c, 10);
		wr(5'(REG_EXT_SYNC), 8'h01);
		EXT_HSYNC <= 1'b1;
		repeat (4) @(posedge CLK);
		chk(HSYNC, 1'b1);
		EXT_HSYNC <= 1'b0;
		EXT_VSYNC <= 1'b1;
		repeat (4) @(posedge CLK);
		chk({HSYNC, VSYNC, CSYNC}, 3'b011);
	endtask : t_stop_ext
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude
	// Main sequence
	initial begin
		{REG_ADDR, REG_WDATA, REG_WR, REG_RD, REFRESH_BUSY, RAM_DONE, EXT_HSYNC, EXT_VSYNC} = '0;
		RESET = 1'b1;
		repeat (4) @(posedge CLK);
		RESET <= 1'b0;
		t_reset();
		t_init();
		t_ctrl();
		t_ram(0);
		t_ram(80);
		t_raster();
		t_stop_ext();
		conclude();
	end
endmodule : test_frame_buffer_timing_gen
